// >>> pkg/flash_erase_host_pkg.sv
// constants and types of the sector erase host controller
// Functional notes
// [R1] erase uses six writes, unlocks then command
// [R2] device preprograms sector itself, host does nothing
// [R3] acceptance window opens at last strobe rise
// [R4] more sectors added by single write
// [R5] gap between sector additions under window time
// [R6] sector loading must not be interrupted
// [R7] stray write in window aborts whole sequence
// [R8] device shows window state on status bit
// [R9] during erase only suspend is honoured
// [R10] hardware reset aborts erase; reissue afterwards
// [R11] completion reported on status and ready_busy_n
// [R12] suspend only valid during sector erase
// [R13] suspend immediate in window, else 35 us
// [R14] suspended sectors read back status byte
// [R15] polling or toggle bits tell suspended apart
// [R16] program during suspend reports normal status
// [R17] autoselect allowed while suspended, returns there
// [R18] resume once continues erase; repeats ignored
// [R19] unlock addresses 555/2AA or AAA/555 bytewise
// [R20] protect verify read at sector offset 02
// [R21] sector erase command data is 30
// [R22] suspend B0, resume 30, any address
// [R23] autoselect offsets 00 and 01 give codes
// [R24] device timers derived from its oscillator
package flash_erase_host_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam int         CTRL_BYTE_BIT = 8;
  localparam int         ST_BUSY    = 0;
  localparam int         ST_WINDOW  = 1;
  localparam int         ST_SUSP    = 2;
  localparam int         ST_SETTLE  = 3;
  localparam int         ST_REFUSED = 4;
  localparam int         ST_ABORTED = 5;
  localparam int         ST_RDY     = 6;
  localparam int         ST_LATE    = 7;
  localparam int         ST_ERASING = 8;

  // ****************************************
  // operations written to the control register
  // ****************************************
  localparam logic [2:0] OP_HWRESET = 3'h0;
  localparam logic [2:0] OP_ERASE   = 3'h1;
  localparam logic [2:0] OP_ADD     = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME  = 3'h4;
  localparam logic [2:0] OP_READ    = 3'h5;
  localparam logic [2:0] OP_AUTOSEL = 3'h6;
  localparam logic [2:0] OP_SWRESET = 3'h7;

  // ****************************************
  // flash command addresses and data
  // ****************************************
  localparam logic [11:0] UNLOCK1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h2aa;
  localparam logic [11:0] UNLOCK1_BYTE = 12'haaa;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h555;
  localparam logic [7:0]  DAT_UNLOCK1  = 8'haa;
  localparam logic [7:0]  DAT_UNLOCK2  = 8'h55;
  localparam logic [7:0]  DAT_SETUP    = 8'h80;
  localparam logic [7:0]  DAT_SECTOR   = 8'h30;
  localparam logic [7:0]  DAT_SUSPEND  = 8'hb0;
  localparam logic [7:0]  DAT_RESUME   = 8'h30;
  localparam logic [7:0]  DAT_AUTOSEL  = 8'h90;
  localparam logic [7:0]  DAT_SWRESET  = 8'hf0;
  localparam logic [2:0]  ERASE_STEPS   = 3'h6;
  localparam logic [2:0]  AUTOSEL_STEPS = 3'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS      = 100;
  localparam int WINDOW_US   = 50;
  localparam int WINDOW_CYC  = WINDOW_US * 1000 / CLK_NS;
  localparam int SUSPEND_US  = 35;
  localparam int SUSPEND_CYC = (SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RESET_NS    = 500;
  localparam int RESET_CYC   = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = 2;
  localparam int READ_CYC    = 2;
  localparam int ADD_LEAD    = 1 + STROBE_CYC;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOVER, S_HWRST} eng_state_t;

endpackage

// >>> test/flash_device_model.sv
// behavioural parallel nor flash for sector erase and suspend
`timescale 1ns/1ps
module flash_device_model #(
  parameter int         WIN_CYC   = 500,
  parameter int         ERASE_CYC = 800,
  parameter logic [7:0] MFR_CODE  = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_CODE  = 8'h3c   // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] wdat,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  output logic      [15:0] rdat,
  output logic             ready_busy_n
);
  int          step = 0, win = 0, ers = 0;
  logic        susp = 0, asel = 0;
  logic [8:0]  sect = 0;
  logic [15:0] last = 16'h0, now;
  logic [7:0]  d;
  function automatic logic ok(input int s, input logic [7:0] v);
    case (s)
      0, 3: return v == 8'haa;
      1, 4: return v == 8'h55;
      2: return v == 8'h80 || v == 8'h90;
      default: return v == 8'h30;
    endcase
  endfunction
  // command decode at the strobe's rising edge
  always @(posedge we_n or negedge reset_n) begin
    d = wdat[7:0];
    if (!reset_n) begin win = 0; ers = 0; susp = 0; step = 0; asel = 0; end
    else if (win > 0 && d == 8'h30) win = WIN_CYC;
    else if ((win > 0 || ers > 0) && !susp && d == 8'hb0) begin win = 0; susp = 1; end
    else if (susp && d == 8'h30) susp = 0;
    else if (win > 0) begin win = 0; ers = 0; end
    else if (ers > 0 && !susp) step = 0;
    else if (d == 8'hf0) begin step = 0; asel = 0; end
    else begin
      step = ok(step, d) ? step + 1 : 0;
      if (step == 3 && d == 8'h90) begin asel = 1; step = 0; end
      if (step == 6) sect = addr[20:12];
      if (step == 6) begin win = WIN_CYC; ers = ERASE_CYC; step = 0; end
    end
  end
  // timers on the far edge so they never race the strobe decode
  always @(negedge clk) begin
    if (win > 0) win = win - 1;
    else if (ers > 0 && !susp) ers = ers - 1;
    if (!ce_n && !oe_n) last = now;
  end
  // released bus shows the inverse of the last value, never a stale copy
  assign now = asel ? {8'h0, addr[1] ? 8'h00 : addr[0] ? DEV_CODE : MFR_CODE}
    : ((win > 0 || ers > 0) && !(susp && addr[20:12] != sect))
    ? {8'h0, susp, 3'h0, win > 0, 3'h0} : addr[15:0];
  assign rdat = (!ce_n && !oe_n) ? now : ~last;
  assign ready_busy_n = !((win > 0 || ers > 0) && !susp);
endmodule

// >>> test/sector_erase_suspend_sequencer_test.sv
// self-checking bench for the ahb sector erase host
`timescale 1ns/1ps
module sector_erase_suspend_sequencer_test;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, dq_oe, ce_n, oe_n, we_n, byte_n, rst_n, rb_n;
  logic [20:0] faddr;
  logic [15:0] dq_o, dq_i;
  logic [21:0] wq[$];
  int          n_mismatch = 0, checked = 0;
  always #50 hclk = ~hclk;
  // pin monitor: drive enable, chip enable, address, command at each strobe rise
  always @(posedge we_n) wq.push_back({dq_oe, ce_n, faddr[11:0], dq_o[7:0]});
  flash_erase_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_byte_n(byte_n), .flash_reset_n(rst_n),
    .ready_busy_n(rb_n));
  flash_device_model mdl (.clk(hclk), .addr(faddr), .wdat(dq_o), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .reset_n(rst_n), .rdat(dq_i), .ready_busy_n(rb_n));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one bus phase, held until hready is seen high
  task automatic hold;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin n_mismatch++; final_report; end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    hold;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    hold;
    rd = hrdata;
  endtask
  task automatic op(input logic [2:0] o, input logic bm);
    bus(1'b1, 8'h00, {23'h0, bm, 5'h0, o});
  endtask
  // status polling bounded so a stuck engine ends the run
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin bus(1'b0, 8'h08, 32'h0); n++; end while (rd[b] !== v && n < 1000);
    if (rd[b] !== v) begin n_mismatch++; final_report; end
  endtask
  // read one flash location through the engine into rd
  task automatic rd_at(input logic [31:0] a, input logic bm);
    bus(1'b1, 8'h04, a);
    op(3'h5, bm);
    wait_st(0, 0);
    bus(1'b0, 8'h0c, 32'h0);
  endtask
  task automatic t_idle;
    chk("hresp", hresp, 0);
    chk("flash_reset_n", rst_n, 1);
    chk("flash_we_n", we_n, 1);
    chk("idle pins", {ce_n, oe_n, dq_oe, byte_n}, 4'b1101);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 0);
    $display("test idle done");
  endtask
  task automatic t_erase(input logic bm);
    logic [11:0] u1, u2, ea[6];
    logic [7:0]  ed[6];
    u1 = bm ? 12'haaa : 12'h555;
    u2 = bm ? 12'h555 : 12'h2aa;
    ea = '{u1, u2, u1, u1, u2, 12'h123};
    ed = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h30};
    wq.delete();
    bus(1'b1, 8'h04, 32'h0c7123);
    op(3'h1, bm);
    wait_st(0, 0);
    chk("writes", wq.size(), 6);
    chk("byte pin", byte_n, !bm);
    foreach (ea[i]) chk("step", wq[i], {2'b10, ea[i], ed[i]});
    chk("window", rd[1], 1);
    op(3'h2, bm);
    wait_st(0, 0);
    chk("add", wq[6], {2'b10, 12'h123, 8'h30});
    op(3'h3, bm);
    wait_st(0, 0);
    chk("suspend cmd", wq[7][7:0], 8'hb0);
    chk("suspended", rd[2:1], 2'b10);
    op(3'h6, bm);
    wait_st(0, 0);
    rd_at(32'h0c7000, bm);
    chk("maker code", rd, 32'h5a);
    op(3'h7, bm);
    wait_st(0, 0);
    rd_at(32'h001123, bm);
    chk("other sector", rd, 32'h1123);
    rd_at(32'h0c7123, bm);
    chk("suspended read", rd[7:0], 8'h80);
    op(3'h4, bm);
    wait_st(0, 0);
    chk("resumed", rd[2], 0);
    op(3'h3, bm);
    wait_st(0, 0);
    chk("settling", rd[3:2], 2'b11);
    op(3'h4, bm);
    wait_st(0, 0);
    op(3'h4, bm);
    wait_st(0, 0);
    chk("second resume", rd[4], 1);
    bus(1'b1, 8'h08, 32'h10);
    wait_st(8, 0);
    chk("ready", rd[6], 1);
    $display("test erase mode %0d done", bm);
  endtask
  task automatic t_abort;
    bus(1'b1, 8'h04, 32'h0c7123);
    op(3'h1, 1'b0);
    wait_st(0, 0);
    op(3'h7, 1'b0);
    wait_st(0, 0);
    chk("aborted", {rd[5], rd[1]}, 2'b10);
    op(3'h2, 1'b0);
    wait_st(0, 0);
    chk("late add", {rd[7], rd[4]}, 2'b11);
    bus(1'b1, 8'h08, 32'hb0);
    $display("test abort done");
  endtask
  task automatic t_hwreset;
    int n;
    n = 0;
    op(3'h0, 1'b0);
    repeat (20) begin @(posedge hclk); n += (rst_n === 1'b0); end
    chk("reset width", n, 5);
    $display("test hwreset done");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_idle;
    t_erase(1'b0);
    t_erase(1'b1);
    t_abort;
    t_hwreset;
    final_report;
  end
endmodule

// >>> verilog/flash_erase_host.sv
// ahb-lite controlled host that drives sector erase sequences into a parallel nor flash
`timescale 1ns/1ps
module flash_erase_host #(
  parameter int ADDR_W = 21
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [15:0]       flash_dq_i,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_byte_n,
  output logic                   flash_reset_n,
  input  wire logic              ready_busy_n
);

  // ****************************************
  // state
  // ****************************************
  flash_erase_host_pkg::eng_state_t state_q;
  logic              wr_pend_q;
  logic [7:0]        addr_q;
  logic              byte_mode_q;
  logic [ADDR_W-1:0] sect_addr_q;
  logic [15:0]       rdata_q;
  logic [2:0]        op_q;
  logic [2:0]        step_q;
  logic [3:0]        cnt_q;
  logic [9:0]        win_q;
  logic [8:0]        settle_q;
  logic              susp_q;
  logic              erasing_q;
  logic              refused_q;
  logic              aborted_q;
  logic              late_q;
  logic [2:0]        fall_cnt_q;

  logic       take;
  logic       cmd_req;
  logic [2:0] cmd_op;
  logic       op_ok;
  logic       launch;
  logic       abort;
  logic       win_open;
  logic       win_load;
  logic       last_step;
  logic       is_read;
  logic       st_clr;

  // ****************************************
  // command sequence tables
  // ****************************************
  function automatic logic [ADDR_W-1:0] step_addr(input logic [2:0] op, input logic [2:0] idx,
                                                  input logic bm, input logic [ADDR_W-1:0] sa);
    logic [11:0] u;
    // unlock pattern repeats every three steps
    if ((idx == 3'h1) || (idx == 3'h4)) begin
      u = bm ? flash_erase_host_pkg::UNLOCK2_BYTE : flash_erase_host_pkg::UNLOCK2_WORD; // R19
    end else begin
      u = bm ? flash_erase_host_pkg::UNLOCK1_BYTE : flash_erase_host_pkg::UNLOCK1_WORD; // R19
    end
    if ((op == flash_erase_host_pkg::OP_ADD) || (op == flash_erase_host_pkg::OP_READ) ||
        ((op == flash_erase_host_pkg::OP_ERASE) && (idx == 3'h5))) begin
      return sa;
    end else if ((op == flash_erase_host_pkg::OP_ERASE) ||
                 (op == flash_erase_host_pkg::OP_AUTOSEL)) begin
      return ADDR_W'(u);
    end else begin
      return '0; // suspend, resume and reset ignore the address
    end
  endfunction

  function automatic logic [7:0] step_data(input logic [2:0] op, input logic [2:0] idx);
    logic [7:0] d;
    d = flash_erase_host_pkg::DAT_SWRESET;
    if ((op == flash_erase_host_pkg::OP_ERASE) || (op == flash_erase_host_pkg::OP_AUTOSEL)) begin
      case (idx)
        3'h0, 3'h3: d = flash_erase_host_pkg::DAT_UNLOCK1;
        3'h1, 3'h4: d = flash_erase_host_pkg::DAT_UNLOCK2;
        3'h2: d = (op == flash_erase_host_pkg::OP_ERASE) ? flash_erase_host_pkg::DAT_SETUP
                                                          : flash_erase_host_pkg::DAT_AUTOSEL;
        default: d = flash_erase_host_pkg::DAT_SECTOR; // R1 R21
      endcase
    end else begin
      case (op)
        flash_erase_host_pkg::OP_ADD:     d = flash_erase_host_pkg::DAT_SECTOR;  // R4 R21
        flash_erase_host_pkg::OP_SUSPEND: d = flash_erase_host_pkg::DAT_SUSPEND; // R22
        flash_erase_host_pkg::OP_RESUME:  d = flash_erase_host_pkg::DAT_RESUME;  // R22
        default:                          d = flash_erase_host_pkg::DAT_SWRESET;
      endcase
    end
    return d;
  endfunction

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign take = hsel & htrans[1] & hready;

  // address phase capture; zero wait states so hreadyout stays high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      addr_q    <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is fetched in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        flash_erase_host_pkg::REG_CTRL:   hrdata <= {23'h0, byte_mode_q, 5'h00, op_q};
        flash_erase_host_pkg::REG_ADDR:   hrdata <= 32'(sect_addr_q);
        flash_erase_host_pkg::REG_STATUS: hrdata <= {23'h0, erasing_q, late_q, ready_busy_n,
                                                     aborted_q, refused_q, (settle_q != 9'h000),
                                                     susp_q, win_open,
                                                     (state_q != flash_erase_host_pkg::S_IDLE)};
        flash_erase_host_pkg::REG_RDATA:  hrdata <= {16'h0000, rdata_q};
        default:                          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_mode_q  <= 1'b0;
      sect_addr_q  <= '0;
      flash_byte_n <= 1'b1;
    end else if (wr_pend_q && (addr_q == flash_erase_host_pkg::REG_ADDR)) begin
      sect_addr_q <= hwdata[ADDR_W-1:0];
    end else if (cmd_req) begin
      byte_mode_q  <= hwdata[flash_erase_host_pkg::CTRL_BYTE_BIT];
      flash_byte_n <= !hwdata[flash_erase_host_pkg::CTRL_BYTE_BIT]; // R19
    end
  end

  // ****************************************
  // command acceptance
  // ****************************************
  assign cmd_req  = wr_pend_q && (addr_q == flash_erase_host_pkg::REG_CTRL) &&
                    (state_q == flash_erase_host_pkg::S_IDLE);
  assign cmd_op   = hwdata[2:0];
  assign win_open = (win_q != 10'h000);
  assign st_clr   = wr_pend_q && (addr_q == flash_erase_host_pkg::REG_STATUS);

  // the flash would ignore these, so they never reach its pins
  always_comb begin
    case (cmd_op)
      flash_erase_host_pkg::OP_ADD:     op_ok = (32'(win_q) > flash_erase_host_pkg::ADD_LEAD); // R5
      flash_erase_host_pkg::OP_ERASE:   op_ok = !susp_q && !erasing_q;
      flash_erase_host_pkg::OP_SUSPEND: op_ok = !susp_q && (win_open || erasing_q); // R12
      flash_erase_host_pkg::OP_RESUME:  op_ok = susp_q; // R18
      flash_erase_host_pkg::OP_HWRESET: op_ok = 1'b1;
      default:                          op_ok = !erasing_q || susp_q || win_open; // R9
    endcase
  end

  assign launch = cmd_req && op_ok;
  // a launched autoselect, software reset or hardware reset inside the window throws the whole load away; erase and resume are refused there
  assign abort  = launch && win_open && (cmd_op != flash_erase_host_pkg::OP_ADD) &&
                  (cmd_op != flash_erase_host_pkg::OP_SUSPEND) &&
                  (cmd_op != flash_erase_host_pkg::OP_READ); // R7

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refused_q <= 1'b0;
      aborted_q <= 1'b0;
      late_q    <= 1'b0;
    end else begin
      refused_q <= (wr_pend_q && (addr_q == flash_erase_host_pkg::REG_CTRL) && !launch) |
                   (refused_q & !(st_clr & hwdata[flash_erase_host_pkg::ST_REFUSED]));
      aborted_q <= abort | (aborted_q & !(st_clr & hwdata[flash_erase_host_pkg::ST_ABORTED]));
      late_q    <= (cmd_req && !op_ok && (cmd_op == flash_erase_host_pkg::OP_ADD)) |
                   (late_q & !(st_clr & hwdata[flash_erase_host_pkg::ST_LATE])); // R5
    end
  end

  // ****************************************
  // bus cycle engine
  // ****************************************
  assign is_read   = (op_q == flash_erase_host_pkg::OP_READ);
  assign last_step = (op_q == flash_erase_host_pkg::OP_ERASE) ?
                       (step_q == flash_erase_host_pkg::ERASE_STEPS - 3'h1) :
                     (op_q == flash_erase_host_pkg::OP_AUTOSEL) ?
                       (step_q == flash_erase_host_pkg::AUTOSEL_STEPS - 3'h1) : 1'b1;
  // rising write strobe of the command that opens or extends the window
  assign win_load  = (state_q == flash_erase_host_pkg::S_STROBE) && (cnt_q == 4'h0) && last_step &&
                     ((op_q == flash_erase_host_pkg::OP_ERASE) ||
                      (op_q == flash_erase_host_pkg::OP_ADD));

  // each step runs setup, strobe, recover without a break, so a load is never split
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q       <= flash_erase_host_pkg::S_IDLE;
      op_q          <= flash_erase_host_pkg::OP_READ;
      step_q        <= 3'h0;
      cnt_q         <= 4'h0;
      rdata_q       <= 16'h0000;
      flash_addr    <= '0;
      flash_dq_o    <= 16'h0000;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end else begin
      case (state_q)
        flash_erase_host_pkg::S_IDLE: begin
          if (launch && (cmd_op == flash_erase_host_pkg::OP_HWRESET)) begin
            op_q          <= cmd_op;
            flash_reset_n <= 1'b0; // R10
            cnt_q         <= 4'(flash_erase_host_pkg::RESET_CYC - 1);
            state_q       <= flash_erase_host_pkg::S_HWRST;
          end else if (launch) begin
            op_q    <= cmd_op;
            step_q  <= 3'h0;
            state_q <= flash_erase_host_pkg::S_SETUP;
          end
        end
        flash_erase_host_pkg::S_SETUP: begin
          flash_addr  <= step_addr(op_q, step_q, byte_mode_q, sect_addr_q); // R1 R19
          flash_dq_o  <= {8'h00, step_data(op_q, step_q)};
          flash_dq_oe <= !is_read;
          flash_ce_n  <= 1'b0;
          cnt_q       <= 4'(is_read ? flash_erase_host_pkg::READ_CYC
                                    : flash_erase_host_pkg::STROBE_CYC);
          state_q     <= flash_erase_host_pkg::S_STROBE;
        end
        flash_erase_host_pkg::S_STROBE: begin
          if (cnt_q != 4'h0) begin
            flash_we_n <= is_read;
            flash_oe_n <= !is_read;
            cnt_q      <= cnt_q - 4'h1;
          end else begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (is_read) begin
              rdata_q <= flash_dq_i;
            end
            state_q <= flash_erase_host_pkg::S_RECOVER;
          end
        end
        flash_erase_host_pkg::S_RECOVER: begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          if (last_step) begin
            state_q <= flash_erase_host_pkg::S_IDLE;
          end else begin
            step_q  <= step_q + 3'h1; // R6
            state_q <= flash_erase_host_pkg::S_SETUP;
          end
        end
        flash_erase_host_pkg::S_HWRST: begin
          if (cnt_q == 4'h0) begin
            flash_reset_n <= 1'b1;
            state_q       <= flash_erase_host_pkg::S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= flash_erase_host_pkg::S_IDLE;
      endcase
    end
  end

  // ****************************************
  // window and suspend tracking
  // ****************************************
  // host copy of the acceptance window; suspend or a stray command closes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= 10'h000;
    end else if (abort || (launch && ((cmd_op == flash_erase_host_pkg::OP_SUSPEND) ||
                                      (cmd_op == flash_erase_host_pkg::OP_HWRESET)))) begin
      win_q <= 10'h000; // R13
    end else if (win_load) begin
      win_q <= 10'(flash_erase_host_pkg::WINDOW_CYC); // R3 R5
    end else if (win_open) begin
      win_q <= win_q - 10'h001;
    end
  end

  // active erase needs up to the suspend latency; inside the window it is instant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_q   <= 1'b0;
      settle_q <= 9'h000;
    end else if (launch && (cmd_op == flash_erase_host_pkg::OP_SUSPEND)) begin
      susp_q   <= 1'b1;
      settle_q <= win_open ? 9'h000 : 9'(flash_erase_host_pkg::SUSPEND_CYC); // R13
    end else if (launch && ((cmd_op == flash_erase_host_pkg::OP_RESUME) ||
                            (cmd_op == flash_erase_host_pkg::OP_HWRESET))) begin
      susp_q   <= 1'b0; // R18
      settle_q <= 9'h000;
    end else if (settle_q != 9'h000) begin
      settle_q <= settle_q - 9'h001;
    end
  end

  // erase in flight until ready comes back after the window, unless suspended
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      erasing_q <= 1'b0;
    end else if (win_load) begin
      erasing_q <= 1'b1;
    end else if (abort || (launch && (cmd_op == flash_erase_host_pkg::OP_HWRESET))) begin
      erasing_q <= 1'b0; // R10
    end else if (!win_open && !susp_q && ready_busy_n &&
                 (state_q == flash_erase_host_pkg::S_IDLE)) begin
      erasing_q <= 1'b0; // R11
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // helper: write strobes issued within the current operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_cnt_q <= 3'h0;
    end else if (state_q == flash_erase_host_pkg::S_IDLE) begin
      fall_cnt_q <= 3'h0;
    end else if ($fell(flash_we_n)) begin
      fall_cnt_q <= fall_cnt_q + 3'h1;
    end
  end

  sequence s_we_fall;
    $fell(flash_we_n);
  endsequence

  sequence s_erase_done;
    (state_q == flash_erase_host_pkg::S_RECOVER) && last_step &&
    (op_q == flash_erase_host_pkg::OP_ERASE);
  endsequence

  a_erase_six_strobes: assert property (s_erase_done |-> fall_cnt_q == 3'h6) // R1
    else $error("erase did not issue six writes");
  a_unlock_first_addr: assert property (s_we_fall and (step_q == 3'h0) && !is_read &&
      (op_q == flash_erase_host_pkg::OP_ERASE) |-> flash_addr == ADDR_W'(byte_mode_q ?
      flash_erase_host_pkg::UNLOCK1_BYTE : flash_erase_host_pkg::UNLOCK1_WORD)) // R19
    else $error("first unlock address wrong");
  a_sector_cmd_data: assert property (s_we_fall and (op_q == flash_erase_host_pkg::OP_ADD) |->
      (flash_dq_o[7:0] == 8'h30) && (flash_addr == sect_addr_q) && win_open) // R4 R21
    else $error("sector load write wrong or outside window");
  a_window_reload: assert property (win_load |=> (win_q == 10'(flash_erase_host_pkg::WINDOW_CYC))
      ##1 (win_q == 10'(flash_erase_host_pkg::WINDOW_CYC - 1))) // R3
    else $error("window not reloaded at strobe rise");
  a_suspend_code: assert property (s_we_fall and (op_q == flash_erase_host_pkg::OP_SUSPEND) |->
      flash_dq_o[7:0] == 8'hb0) // R22
    else $error("suspend data wrong");
  a_stray_aborts: assert property (abort |=> aborted_q && !win_open && !erasing_q) // R7
    else $error("stray write in window not flagged");
  a_hw_reset_len: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*5] ##1
      flash_reset_n) // R10
    else $error("hardware reset pulse length wrong");
  a_suspend_settle: assert property (launch && (cmd_op == flash_erase_host_pkg::OP_SUSPEND) &&
      !win_open |=> (settle_q == 9'(flash_erase_host_pkg::SUSPEND_CYC)) && susp_q) // R13
    else $error("suspend latency not timed");
  a_resume_only_susp: assert property (s_we_fall and (op_q == flash_erase_host_pkg::OP_RESUME)
      |-> !susp_q && (flash_dq_o[7:0] == 8'h30)) // R18 R22
    else $error("resume strobe wrong or suspend not left");

endmodule
